// >>> hdl/bce_top.sv
// Branch condition evaluator with flag register and bus access
//
// Summary of operation
// - Code 1000 is always true, code 0000 is never true.
// - Code 0111 true when carry set, 1111 true when carry clear.
// - Code 0110 true when zero set, 1110 true when zero clear.
// - Code 0100 true when overflow set, 1100 true when overflow clear.
// - Code 1001 true when sign xor overflow is 0, code 0001 when 1.
// - Code 1010 true when zero or (sign xor overflow) is 0, 0010 when 1.
// - Code 1011 true when carry and zero both clear, 0011 when either set.
// - Equal and unequal reuse zero codes; unsigned at least and below reuse carry codes.
`default_nettype none

module bce_top (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  // Avalon-MM register slave
  input  wire logic [bce_pkg::ADDR_W-1:0] avs_address_in,
  input  wire logic                       avs_read_in,
  input  wire logic                       avs_write_in,
  input  wire logic [bce_pkg::DATA_W-1:0] avs_writedata_in,
  input  wire logic [bce_pkg::BE_W-1:0]   avs_byteenable_in,
  output logic      [bce_pkg::DATA_W-1:0] avs_readdata_out,
  output logic                            avs_waitrequest_out,
  // Core branch request
  input  wire logic                       core_eval_in,
  input  wire logic [3:0]                 core_cond_in,
  // Core flag update
  input  wire logic                       core_flags_wr_in,
  input  wire logic [7:0]                 core_flags_in,
  // Verdict to the program counter logic
  output logic                            branch_taken_out,
  output logic                            branch_valid_out,
  // Current flag byte
  output logic      [7:0]                 flags_out
);

  // Bus side
  bce_pkg::bce_avmm_req_t    bus_req;
  logic                      bus_capture;
  logic                      bus_commit;
  logic                      bus_wait;
  logic                      wr_lane0;
  logic                      wr_lane1;
  logic [bce_pkg::DATA_W-1:0] rd_word;

  // Registers
  logic [7:0]  flags_q;
  logic [3:0]  cond_sel_q;
  logic [0:0]  ctrl_q;
  logic [15:0] taken_cnt_q;
  logic [15:0] skip_cnt_q;
  logic [3:0]  last_cc_q;
  logic        last_take_q;
  logic        taken_q;
  logic        valid_q;
  logic [bce_pkg::DATA_W-1:0] rdata_q;

  // Evaluator results
  bce_pkg::bce_flags_t flags_view;
  logic                core_verdict;
  logic                soft_verdict;
  logic [15:0]         all_codes;

  // Write strobes per register
  logic wr_cond_sel;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_counts;

  // Gather the held request
  always_comb begin
    bus_req.address    = avs_address_in;
    bus_req.read       = avs_read_in;
    bus_req.write      = avs_write_in;
    bus_req.writedata  = avs_writedata_in;
    bus_req.byteenable = avs_byteenable_in;
  end

  // Bus handshake
  bce_avmm_slave u_slave (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .req_in          (bus_req),
    .waitrequest_out (bus_wait),
    .capture_out     (bus_capture),
    .commit_out      (bus_commit)
  );

  // Byte lanes of a committed write
  assign wr_lane0 = bus_commit & bus_req.write & bus_req.byteenable[0];
  assign wr_lane1 = bus_commit & bus_req.write & bus_req.byteenable[1];

  // Address decode of committed writes
  assign wr_cond_sel = wr_lane0 & (bus_req.address == bce_pkg::OFF_COND_SEL);
  assign wr_ctrl     = wr_lane0 & (bus_req.address == bce_pkg::OFF_CTRL);
  assign wr_flags    = wr_lane0 & (bus_req.address == bce_pkg::OFF_FLAGS);
  assign wr_counts   = (wr_lane0 | wr_lane1) &
                       ((bus_req.address == bce_pkg::OFF_TAKEN_CNT) |
                        (bus_req.address == bce_pkg::OFF_SKIP_CNT));

  // Tested flags from the flag register
  assign flags_view = bce_pkg::unpack_flags(flags_q);

  // Core request evaluated in its own cycle
  bce_cond_eval u_core_eval (
    .cond_in       (core_eval_in),
    .flags_in      (flags_view),
    .code_in       (core_cond_in),
    .result_out    (core_verdict),
    .all_codes_out ()
  );

  // Software test code and the whole verdict table
  bce_cond_eval u_soft_eval (
    .cond_in       (1'b1),
    .flags_in      (flags_view),
    .code_in       (cond_sel_q),
    .result_out    (soft_verdict),
    .all_codes_out (all_codes)
  );

  // Flag register, core update wins over a bus write unless frozen
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flags_q <= bce_pkg::FLAGS_RESET;
    end else if (core_flags_wr_in && !ctrl_q[bce_pkg::CTRL_FREEZE_POS]) begin
      flags_q <= core_flags_in;
    end else if (wr_flags) begin
      flags_q <= bus_req.writedata[7:0];
    end
  end

  // Software test code select
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cond_sel_q <= bce_pkg::COND_SEL_RESET;
    end else if (wr_cond_sel) begin
      cond_sel_q <= bus_req.writedata[3:0];
    end
  end

  // Control register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= bce_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= bus_req.writedata[bce_pkg::CTRL_FREEZE_POS +: 1];
    end
  end

  // Registered verdict to the core
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      taken_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      taken_q <= core_verdict;
      valid_q <= core_eval_in;
    end
  end

  // Last evaluated code and verdict
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      last_cc_q   <= bce_pkg::COND_SEL_RESET;
      last_take_q <= 1'b0;
    end else if (core_eval_in) begin
      last_cc_q   <= core_cond_in;
      last_take_q <= core_verdict;
    end
  end

  // Taken counter, a count in the clearing cycle survives
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      taken_cnt_q <= bce_pkg::COUNT_RESET;
    end else if (wr_counts) begin
      taken_cnt_q <= (core_eval_in && core_verdict) ? 16'h0001 : bce_pkg::COUNT_RESET;
    end else if (core_eval_in && core_verdict) begin
      taken_cnt_q <= 16'(taken_cnt_q + 16'h0001);
    end
  end

  // Not-taken counter, same clearing behaviour
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      skip_cnt_q <= bce_pkg::COUNT_RESET;
    end else if (wr_counts) begin
      skip_cnt_q <= (core_eval_in && !core_verdict) ? 16'h0001 : bce_pkg::COUNT_RESET;
    end else if (core_eval_in && !core_verdict) begin
      skip_cnt_q <= 16'(skip_cnt_q + 16'h0001);
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    rd_word = '0;
    unique case (bus_req.address)
      bce_pkg::OFF_COND_SEL: begin
        rd_word[3:0] = cond_sel_q;
      end
      bce_pkg::OFF_STATUS: begin
        rd_word[bce_pkg::STAT_SOFT_POS]          = soft_verdict;
        rd_word[bce_pkg::STAT_LAST_TAKE_POS]     = last_take_q;
        rd_word[bce_pkg::STAT_LAST_CC_LSB +: 4]  = last_cc_q;
      end
      bce_pkg::OFF_ALL_CODES: begin
        rd_word[15:0] = all_codes;
      end
      bce_pkg::OFF_TAKEN_CNT: begin
        rd_word[15:0] = taken_cnt_q;
      end
      bce_pkg::OFF_SKIP_CNT: begin
        rd_word[15:0] = skip_cnt_q;
      end
      bce_pkg::OFF_CTRL: begin
        rd_word[bce_pkg::CTRL_FREEZE_POS +: 1] = ctrl_q;
      end
      bce_pkg::OFF_FLAGS: begin
        rd_word[7:0] = flags_q;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  // Read data held from the first cycle of a read
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= '0;
    end else if (bus_capture && bus_req.read) begin
      rdata_q <= rd_word;
    end
  end

  // Outputs
  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = bus_wait;
  assign branch_taken_out    = taken_q;
  assign branch_valid_out    = valid_q;
  assign flags_out           = flags_q;

endmodule

`default_nettype wire

// >>> inc/bce_pkg.sv
// Shared constants and types for the branch condition evaluator
`default_nettype none

package bce_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFF_COND_SEL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ALL_CODES = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TAKEN_CNT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_SKIP_CNT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_FLAGS     = 8'hfc;

  // Flag register layout
  localparam int FLAG_C_POS = 7;
  localparam int FLAG_Z_POS = 6;
  localparam int FLAG_S_POS = 5;
  localparam int FLAG_V_POS = 4;

  // Status register layout
  localparam int STAT_SOFT_POS      = 0;
  localparam int STAT_LAST_TAKE_POS = 1;
  localparam int STAT_LAST_CC_LSB   = 4;

  // Control register layout
  localparam int CTRL_FREEZE_POS = 0;

  // Reset values
  localparam logic [7:0]  FLAGS_RESET    = 8'h00;
  localparam logic [3:0]  COND_SEL_RESET = 4'h0;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [0:0]  CTRL_RESET     = 1'h0;

  // Condition codes
  localparam logic [3:0] CC_NEVER            = 4'h0;
  localparam logic [3:0] CC_SIGNED_BELOW     = 4'h1;
  localparam logic [3:0] CC_SIGNED_AT_MOST   = 4'h2;
  localparam logic [3:0] CC_UNSIGNED_AT_MOST = 4'h3;
  localparam logic [3:0] CC_OVERFLOW_SET     = 4'h4;
  localparam logic [3:0] CC_SIGN_NEGATIVE    = 4'h5;
  localparam logic [3:0] CC_ZERO_SET         = 4'h6;
  localparam logic [3:0] CC_CARRY_SET        = 4'h7;
  localparam logic [3:0] CC_ALWAYS           = 4'h8;
  localparam logic [3:0] CC_SIGNED_AT_LEAST  = 4'h9;
  localparam logic [3:0] CC_SIGNED_ABOVE     = 4'ha;
  localparam logic [3:0] CC_UNSIGNED_ABOVE   = 4'hb;
  localparam logic [3:0] CC_OVERFLOW_CLEAR   = 4'hc;
  localparam logic [3:0] CC_SIGN_POSITIVE    = 4'hd;
  localparam logic [3:0] CC_RESULT_NONZERO   = 4'he;
  localparam logic [3:0] CC_CARRY_CLEAR      = 4'hf;

  // Shared encodings
  localparam logic [3:0] CC_EQUAL_TEST        = CC_ZERO_SET;
  localparam logic [3:0] CC_UNEQUAL_TEST      = CC_RESULT_NONZERO;
  localparam logic [3:0] CC_UNSIGNED_AT_LEAST = CC_CARRY_CLEAR;
  localparam logic [3:0] CC_UNSIGNED_BELOW    = CC_CARRY_SET;

  // Flags seen by the evaluator
  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic overflow;
  } bce_flags_t;

  // One bus request as held by the master
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } bce_avmm_req_t;

  // Picks the four tested flags out of the flag byte
  function automatic bce_flags_t unpack_flags(input logic [7:0] raw);
    bce_flags_t f;
    f.carry    = raw[FLAG_C_POS];
    f.zero     = raw[FLAG_Z_POS];
    f.sign     = raw[FLAG_S_POS];
    f.overflow = raw[FLAG_V_POS];
    return f;
  endfunction

endpackage

`default_nettype wire

// >>> hdl/bce_cond_eval.sv
// Combinational condition code evaluator
`default_nettype none

module bce_cond_eval (
  // Code and flags
  input  wire logic                cond_in,
  input  wire bce_pkg::bce_flags_t flags_in,
  input  wire logic [3:0]          code_in,
  // Verdicts
  output logic                     result_out,
  output logic [15:0]              all_codes_out
);

  // Verdict of one code against one flag set
  function automatic logic eval_code(input logic [3:0] code, input bce_pkg::bce_flags_t f);
    logic sv;
    logic r;
    sv = f.sign ^ f.overflow;
    r  = 1'b0;
    unique case (code)
      bce_pkg::CC_NEVER:            r = 1'b0;
      bce_pkg::CC_ALWAYS:           r = 1'b1;
      bce_pkg::CC_CARRY_SET:        r = f.carry;
      bce_pkg::CC_CARRY_CLEAR:      r = ~f.carry;
      bce_pkg::CC_ZERO_SET:         r = f.zero;
      bce_pkg::CC_RESULT_NONZERO:   r = ~f.zero;
      bce_pkg::CC_SIGN_POSITIVE:    r = ~f.sign;
      bce_pkg::CC_SIGN_NEGATIVE:    r = f.sign;
      bce_pkg::CC_OVERFLOW_SET:     r = f.overflow;
      bce_pkg::CC_OVERFLOW_CLEAR:   r = ~f.overflow;
      bce_pkg::CC_SIGNED_AT_LEAST:  r = ~sv;
      bce_pkg::CC_SIGNED_BELOW:     r = sv;
      bce_pkg::CC_SIGNED_ABOVE:     r = ~(f.zero | sv);
      bce_pkg::CC_SIGNED_AT_MOST:   r = f.zero | sv;
      bce_pkg::CC_UNSIGNED_ABOVE:   r = ~f.carry & ~f.zero;
      bce_pkg::CC_UNSIGNED_AT_MOST: r = f.carry | f.zero;
    endcase
    return r;
  endfunction

  // Same-cycle verdict, no storage
  always_comb begin
    result_out = cond_in & eval_code(code_in, flags_in);
  end

  // Verdict of every code at once
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      all_codes_out[i] = eval_code(4'(i), flags_in);
    end
  end

endmodule

`default_nettype wire

// >>> hdl/bce_avmm_slave.sv
// Avalon-MM handshake with one wait state per access
`default_nettype none

module bce_avmm_slave (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // Request from the master
  input  wire bce_pkg::bce_avmm_req_t req_in,
  // Handshake
  output logic                        waitrequest_out,
  output logic                        capture_out,
  output logic                        commit_out
);

  logic wait_q;
  logic wait_d;
  logic active;

  // Any request at all
  assign active = req_in.read | req_in.write;

  // Drop waitrequest for one cycle after a request is seen
  always_comb begin
    wait_d = 1'b1;
    if (wait_q && active) begin
      wait_d = 1'b0;
    end
  end

  // Waitrequest flop, high while idle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= wait_d;
    end
  end

  // Load read data now, commit writes at the accepting edge
  assign waitrequest_out = wait_q;
  assign capture_out     = wait_q & active;
  assign commit_out      = ~wait_q & active;

endmodule

`default_nettype wire

// >>> dv/bce_top_monitor.sv
// Checker of verdict values, verdict timing and bus handshake
`default_nettype none

module bce_top_monitor (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  // Bus handshake
  input wire logic       avs_read_in,
  input wire logic       avs_write_in,
  input wire logic       avs_waitrequest_out,
  // Core side
  input wire logic       core_eval_in,
  input wire logic [3:0] core_cond_in,
  input wire logic       branch_taken_out,
  input wire logic       branch_valid_out,
  input wire logic [7:0] flags_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] f_q;
  logic       inv_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Flags and polarity bit seen by the evaluation one edge back
  always_ff @(posedge clk_in) begin
    f_q   <= flags_out;
    inv_q <= core_cond_in[3];
  end
  // Bit 3 of every code inverts the test of the low three bits
  property p_const;
    core_eval_in && core_cond_in[2:0] == 3'h0 |=> branch_taken_out == inv_q;
  endproperty
  a_const: assert property (p_const) else $error("fixed code verdict wrong");
  property p_carry;
    core_eval_in && core_cond_in[2:0] == 3'h7 |=> branch_taken_out == (f_q[7] ^ inv_q);
  endproperty
  a_carry: assert property (p_carry) else $error("carry verdict wrong");
  property p_zero;
    core_eval_in && core_cond_in[2:0] == 3'h6 |=> branch_taken_out == (f_q[6] ^ inv_q);
  endproperty
  a_zero: assert property (p_zero) else $error("zero verdict wrong");
  property p_sign;
    core_eval_in && core_cond_in[2:0] == 3'h5 |=> branch_taken_out == (f_q[5] ^ inv_q);
  endproperty
  a_sign: assert property (p_sign) else $error("sign verdict wrong");
  property p_ovf;
    core_eval_in && core_cond_in[2:0] == 3'h4 |=> branch_taken_out == (f_q[4] ^ inv_q);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow verdict wrong");
  property p_sgn_below;
    core_eval_in && core_cond_in[2:0] == 3'h1 |=> branch_taken_out == (f_q[5] ^ f_q[4] ^ inv_q);
  endproperty
  a_sgn_below: assert property (p_sgn_below) else $error("signed below verdict wrong");
  property p_sgn_at_most;
    core_eval_in && core_cond_in[2:0] == 3'h2 |=> branch_taken_out == ((f_q[6] | (f_q[5] ^ f_q[4])) ^ inv_q);
  endproperty
  a_sgn_at_most: assert property (p_sgn_at_most) else $error("signed at most verdict wrong");
  property p_uns_at_most;
    core_eval_in && core_cond_in[2:0] == 3'h3 |=> branch_taken_out == ((f_q[7] | f_q[6]) ^ inv_q);
  endproperty
  a_uns_at_most: assert property (p_uns_at_most) else $error("unsigned at most verdict wrong");
  property p_valid;
    core_eval_in |=> branch_valid_out;
  endproperty
  a_valid: assert property (p_valid) else $error("verdict not flagged valid");
  property p_idle;
    !core_eval_in |=> !branch_valid_out && !branch_taken_out;
  endproperty
  a_idle: assert property (p_idle) else $error("verdict without evaluation");
  // One wait state, then back to waiting
  property p_one_wait;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus wait state count wrong");
  // Main scenarios
  c_taken: cover property (core_eval_in ##1 branch_taken_out);
  c_burst: cover property (core_eval_in [*3]);
  c_write: cover property (avs_write_in && !avs_waitrequest_out);
endmodule

bind bce_top bce_top_monitor u_mon (
  .clk_in, .rst_n_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
  .core_eval_in, .core_cond_in, .branch_taken_out, .branch_valid_out, .flags_out
);

`default_nettype wire

// >>> dv/bce_pc_model.sv
// Program counter side model that tallies the verdicts it acts on
`default_nettype none

module bce_pc_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Verdict from the evaluator
  input  wire logic        branch_valid_in,
  input  wire logic        branch_taken_in,
  // Tallies of jumps and fall-throughs
  output logic      [15:0] taken_cnt_out,
  output logic      [15:0] skip_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Count a jump or a fall-through on each valid verdict
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      taken_cnt_out <= 16'h0000;
      skip_cnt_out  <= 16'h0000;
    end else if (branch_valid_in && branch_taken_in) begin
      taken_cnt_out <= taken_cnt_out + 16'h0001;
    end else if (branch_valid_in) begin
      skip_cnt_out <= skip_cnt_out + 16'h0001;
    end
  end
endmodule

`default_nettype wire

// >>> dv/bce_top_tb_top.sv
// Self-checking bench for the branch condition evaluator
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module bce_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in;
  logic        rst_n_in;
  logic [7:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        core_eval_in;
  logic [3:0]  core_cond_in;
  logic        core_flags_wr_in;
  logic [7:0]  core_flags_in;
  logic        branch_taken_out;
  logic        branch_valid_out;
  logic [7:0]  flags_out;
  logic [15:0] tk_cnt;
  logic [15:0] sk_cnt;
  logic [15:0] n_tk;
  logic [15:0] n_sk;
  logic [15:0] tbl;
  logic [31:0] rd;
  logic [31:0] rv;
  logic [7:0]  fl_m;
  logic        pv;
  logic        pt;
  logic        frz;
  int          n_mismatch;
  int          n_compared;
  int          seed;

  // Design and program counter model
  bce_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .core_eval_in(core_eval_in), .core_cond_in(core_cond_in),
    .core_flags_wr_in(core_flags_wr_in), .core_flags_in(core_flags_in), .branch_taken_out(branch_taken_out),
    .branch_valid_out(branch_valid_out), .flags_out(flags_out));
  bce_pc_model u_pc (.clk_in(clk_in), .rst_n_in(rst_n_in), .branch_valid_in(branch_valid_out),
    .branch_taken_in(branch_taken_out), .taken_cnt_out(tk_cnt), .skip_cnt_out(sk_cnt));

  // Expected verdict; flag byte holds carry 7, zero 6, sign 5, overflow 4
  function automatic logic exp_v(input logic [3:0] cc, input logic [7:0] f);
    logic r;
    case (cc[2:0])
      3'h0: r = 1'b0;
      3'h7: r = f[7];
      3'h6: r = f[6];
      3'h5: r = f[5];
      3'h4: r = f[4];
      3'h1: r = f[5] ^ f[4];
      3'h2: r = f[6] | (f[5] ^ f[4]);
      default: r = f[7] | f[6];
    endcase
    return r ^ cc[3];
  endfunction

  // Ends the run with the verdict
  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    avs_address_in   <= a;
    avs_read_in      <= !wr;
    avs_write_in     <= wr;
    avs_writedata_in <= d;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  // One core cycle; checks the verdict of the previous cycle
  task automatic step(input logic ev, input logic [3:0] cc, input logic fw, input logic [7:0] fb);
    @(posedge clk_in);
    core_eval_in     <= ev;
    core_cond_in     <= cc;
    core_flags_wr_in <= fw;
    core_flags_in    <= fb;
    @(negedge clk_in);
    `CHK(branch_valid_out, pv)
    `CHK(branch_taken_out, pt)
    pv = ev;
    pt = ev & exp_v(cc, fl_m);
    if (ev && pt) n_tk++;
    if (ev && !pt) n_sk++;
    if (fw && !frz) fl_m = fb;
  endtask

  // Clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    complete_run();
  end

  // Main sequence
  initial begin
    {n_mismatch, n_compared, n_tk, n_sk, pv, pt, frz, fl_m} = '0;
    seed = 23;
    {rst_n_in, avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = '0;
    {core_eval_in, core_cond_in, core_flags_wr_in, core_flags_in} = '0;
    avs_byteenable_in = 4'hf;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    bus(1'b0, bce_pkg::OFF_FLAGS, 32'h0, rd);
    `CHK(rd, {24'h0, bce_pkg::FLAGS_RESET})
    // Every flag mix by bus or by core, every code back to back
    for (int f = 0; f < 16; f++) begin
      if (f[0]) step(1'b0, 4'h0, 1'b1, {f[3:0], 4'h0});
      else bus(1'b1, bce_pkg::OFF_FLAGS, {24'h0, f[3:0], 4'h5}, rd);
      if (!f[0]) fl_m = {f[3:0], 4'h5};
      bus(1'b0, bce_pkg::OFF_FLAGS, 32'h0, rd);
      `CHK(rd, {24'h0, fl_m})
      bus(1'b0, bce_pkg::OFF_ALL_CODES, 32'h0, rd);
      for (int k = 0; k < 16; k++) tbl[k] = exp_v(k[3:0], fl_m);
      `CHK(rd, {16'h0, tbl})
      for (int k = 0; k < 17; k++) step(k < 16, k[3:0], 1'b0, 8'h00);
    end
    // Flag write and evaluation in one cycle, then random traffic
    step(1'b1, 4'h7, 1'b1, ~fl_m);
    for (int i = 0; i < 400; i++) begin
      rv = $random(seed);
      step(rv[0], rv[4:1], rv[5] & rv[6], rv[15:8]);
    end
    step(1'b0, 4'h0, 1'b0, 8'h00);
    // Frozen flags ignore core writes
    bus(1'b1, bce_pkg::OFF_CTRL, 32'h1, rd);
    frz = 1'b1;
    step(1'b1, 4'h6, 1'b1, ~fl_m);
    step(1'b0, 4'h0, 1'b0, 8'h00);
    `CHK(flags_out, fl_m)
    bus(1'b1, bce_pkg::OFF_CTRL, 32'h0, rd);
    frz = 1'b0;
    // Tallies, clearing and unmapped space
    bus(1'b0, bce_pkg::OFF_TAKEN_CNT, 32'h0, rd);
    `CHK(rd, {16'h0, n_tk})
    bus(1'b0, bce_pkg::OFF_SKIP_CNT, 32'h0, rd);
    `CHK(rd, {16'h0, n_sk})
    `CHK(tk_cnt, n_tk)
    `CHK(sk_cnt, n_sk)
    bus(1'b1, bce_pkg::OFF_TAKEN_CNT, 32'h0, rd);
    bus(1'b0, bce_pkg::OFF_SKIP_CNT, 32'h0, rd);
    `CHK(rd, 32'h0)
    bus(1'b0, 8'h40, 32'h0, rd);
    `CHK(rd, 32'h0)
    // Software code select, status word and byte lane gating
    bus(1'b1, bce_pkg::OFF_COND_SEL, 32'hb, rd);
    bus(1'b0, bce_pkg::OFF_COND_SEL, 32'h0, rd);
    `CHK(rd, 32'hb)
    step(1'b1, 4'h7, 1'b0, 8'h00);
    step(1'b0, 4'h0, 1'b0, 8'h00);
    bus(1'b0, bce_pkg::OFF_STATUS, 32'h0, rd);
    `CHK(rd, {24'h0, 4'h7, 2'h0, exp_v(4'h7, fl_m), exp_v(4'hb, fl_m)})
    avs_byteenable_in <= 4'he;
    bus(1'b1, bce_pkg::OFF_FLAGS, {24'h0, ~fl_m}, rd);
    avs_byteenable_in <= 4'h2;
    @(negedge clk_in);
    `CHK(flags_out, fl_m)
    bus(1'b1, bce_pkg::OFF_TAKEN_CNT, 32'h0, rd);
    avs_byteenable_in <= 4'hf;
    bus(1'b0, bce_pkg::OFF_TAKEN_CNT, 32'h0, rd);
    `CHK(rd, 32'h0)
    complete_run();
  end
endmodule

`default_nettype wire
